// ===== logic/lcd_decoder.sv
`timescale 1ns/1ns
// ----------------------------------------
// instruction buffer
// ----------------------------------------
module lcd_fifo
	import lcd_pkg::*;
#(
	parameter int W     = 10,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output      logic         in_ready,
	output      logic         out_valid,
	output      logic [W-1:0] out_data,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0]   cnt_ff;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem[rd_ff];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ff] <= in_data;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff  <= push ? wr_ff + 1'b1 : wr_ff;
			rd_ff  <= pop ? rd_ff + 1'b1 : rd_ff;
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// Overview of operation
// RL1: clear fills display memory with spaces, address zero, increment mode, 1.52 ms busy
// RL2: home zeroes address and display shift, memory untouched, 1.52 ms busy
// RL3: entry command stores direction; 1 increments address, 0 decrements
// RL4: auto shift only on display memory writes with shift enabled; direction from entry bit
// RL5: display control holds display on, cursor on and blink bits
// RL6: shift command moves cursor with address step or shifts display
// RL7: display shift keeps address counter and moves all lines together
// RL8: in two-line mode cursor passes from position 40 to second line
// RL9: function set selects 8-bit or 4-bit width; 4-bit uses two transfers
// RL10: function set selects line count and font; low two bits ignored
// RL11: glyph address command loads 6-bit address, selects glyph memory
// RL12: display address command loads 7-bit address, selects display memory
// RL13: display addresses 00-4F one line; 00-27 and 40-67 two lines
// RL14: status read returns busy on bit 7 and address counter below
// RL15: data write stores byte in selected memory, busy 43 us
// RL16: data read returns byte from selected memory, busy 43 us; after a cursor shift in glyph memory the next read returns display memory
// RL17: other commands keep the device busy 37 us
// RL18: glyph memory accesses step the address counter like display accesses
// RL19: host waits for busy low before the next instruction
// RL20: each data write steps the address counter by entry direction
// RL21: first read after other than address load or cursor shift is invalid
// RL22: in 4-bit width high nibble travels first on upper lines
// RL23: busy flag stands from acceptance until execution time has elapsed
module lcd_decoder
	import lcd_pkg::*;
#(
	parameter int LONG_CYCLES = LONG_CYC,
	parameter int DATA_CYCLES = DATA_CYC
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       strobe,
	input  wire host_req_s  host_req,
	output      logic [7:0] bus_lines_out,
	output      logic       bus_lines_oe,
	output      logic       busy_flag,
	output      mode_s      mode,
	output      logic [5:0] display_shift,
	input  wire logic [6:0] pix_addr,
	output      logic [7:0] pix_char,
	input  wire logic [5:0] glyph_addr,
	output      logic [7:0] glyph_row
);
	typedef struct packed {
		exec_e       exec;
		logic [17:0] timer;
		logic [6:0]  sweep;
		logic [6:0]  addr_counter;
		logic        sel_glyph;
		mode_s       mode;
		logic [5:0]  shift;
		logic [7:0]  rd_buf;
		logic [7:0]  bus_out;
		logic        oe;
		logic        half;
		logic [3:0]  hi_nib;
		logic        busy;
		logic [7:0]  pix;
		logic [7:0]  glyph;
	} ctl_s;

	ctl_s       ctl_ff;
	ctl_s       nxt_ctl;
	logic [7:0] display_memory [DISPLAY_MEMORY_DEPTH];
	logic [7:0] glyph_memory [CG_DEPTH];
	logic       dm_we;
	logic [6:0] dm_addr;
	logic [7:0] dm_wdata;
	logic       gm_we;
	logic [5:0] gm_addr;
	logic [7:0] gm_wdata;
	logic       push;
	fifo_word_s push_word;
	logic       in_ready;
	logic       out_valid;
	fifo_word_s word;
	logic       pop;
	logic [7:0] rd_val;
	logic [7:0] wr_byte;
	logic       done;

	// ----------------------------------------
	// address arithmetic
	// ----------------------------------------
	function automatic logic [6:0] step_ac(input logic [6:0] ac, input logic inc,
		input logic glyph, input logic two);
		logic [6:0] r;
		r = inc ? ac + 7'h01 : ac - 7'h01;
		if (glyph) begin
			r = {1'b0, r[5:0]}; // [RL18]
		end else if (two) begin
			if (inc && ac == LINE1_END) begin
				r = LINE2_START; // [RL8] [RL13]
			end else if (inc && ac == LINE2_END) begin
				r = ADDR_HOME;
			end else if (!inc && ac == LINE2_START) begin
				r = LINE1_END;
			end else if (!inc && ac == ADDR_HOME) begin
				r = LINE2_END;
			end
		end else if (inc && ac == ONE_END) begin
			r = ADDR_HOME; // [RL13]
		end else if (!inc && ac == ADDR_HOME) begin
			r = ONE_END;
		end
		return r;
	endfunction

	// left when set; all lines share one offset
	function automatic logic [5:0] step_shift(input logic [5:0] s, input logic left);
		if (left) begin
			return (s == SHIFT_LAST) ? 6'h00 : s + 6'h01; // [RL7]
		end
		return (s == 6'h00) ? SHIFT_LAST : s - 6'h01;
	endfunction

	// ----------------------------------------
	// buffer between host and executor
	// ----------------------------------------
	lcd_fifo #(.W($bits(fifo_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk          (core_clk),
		.rst_n             (rst_n),
		.in_valid          (push),
		.in_data           (push_word),
		.in_ready          (in_ready),
		.out_valid         (out_valid),
		.out_data          (word),
		.out_ready         (ctl_ff.exec == ST_IDLE)
	);
	assign pop = out_valid && (ctl_ff.exec == ST_IDLE);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_ctl   = ctl_ff;
		dm_we     = 1'b0;
		dm_addr   = ctl_ff.addr_counter;
		dm_wdata  = word.data;
		gm_we     = 1'b0;
		gm_addr   = ctl_ff.addr_counter[5:0];
		gm_wdata  = word.data;
		push      = 1'b0;
		push_word = '{KIND_CMD, 8'h00};
		done      = 1'b1;
		wr_byte   = host_req.bus_lines;
		rd_val    = (host_req.reg_select) ? ctl_ff.rd_buf
			: {ctl_ff.busy, ctl_ff.addr_counter}; // [RL14] [RL16]
		// host transfers; 4-bit pairs high nibble first
		if (strobe) begin
			if (!ctl_ff.mode.bus_width_sel) begin
				done          = ctl_ff.half; // [RL9]
				nxt_ctl.half  = !ctl_ff.half;
				nxt_ctl.hi_nib = host_req.bus_lines[7:4];
				wr_byte       = {ctl_ff.hi_nib, host_req.bus_lines[7:4]}; // [RL22]
			end
			nxt_ctl.oe = host_req.rd_wr;
			if (host_req.rd_wr) begin
				if (ctl_ff.mode.bus_width_sel) begin
					nxt_ctl.bus_out = rd_val;
				end else begin
					nxt_ctl.bus_out = ctl_ff.half ? {rd_val[3:0], 4'h0}
						: {rd_val[7:4], 4'h0}; // [RL22]
				end
			end
			// a full buffer refuses; the host should have waited
			if (done && in_ready) begin // [RL19]
				push = !(host_req.rd_wr && !host_req.reg_select);
				push_word.data = wr_byte;
				push_word.kind = !host_req.reg_select ? KIND_CMD
					: (host_req.rd_wr ? KIND_RD : KIND_WR);
			end
		end
		// executor
		case (ctl_ff.exec)
			ST_IDLE: begin
				if (pop) begin
					nxt_ctl.exec  = ST_WAIT;
					nxt_ctl.timer = 18'(CMD_CYC); // [RL17]
					case (word.kind)
						KIND_WR: begin
							nxt_ctl.timer = 18'(DATA_CYCLES); // [RL15]
							dm_we = !ctl_ff.sel_glyph;
							gm_we = ctl_ff.sel_glyph;
							nxt_ctl.addr_counter = step_ac(ctl_ff.addr_counter,
								ctl_ff.mode.entry_inc, ctl_ff.sel_glyph,
								ctl_ff.mode.two_line); // [RL20] [RL3]
							if (!ctl_ff.sel_glyph && ctl_ff.mode.auto_display_shift_en) begin
								nxt_ctl.shift = step_shift(ctl_ff.shift,
									ctl_ff.mode.entry_inc); // [RL4]
							end
						end
						KIND_RD: begin
							nxt_ctl.timer  = 18'(DATA_CYCLES); // [RL16]
							nxt_ctl.addr_counter = step_ac(ctl_ff.addr_counter,
								ctl_ff.mode.entry_inc, ctl_ff.sel_glyph,
								ctl_ff.mode.two_line); // [RL18]
							// refill from the stepped address, else the next read repeats
							nxt_ctl.rd_buf = ctl_ff.sel_glyph
								? glyph_memory[nxt_ctl.addr_counter[5:0]]
								: display_memory[nxt_ctl.addr_counter];
						end
						default: begin
							if (word.data[7]) begin
								nxt_ctl.addr_counter = word.data[6:0]; // [RL12]
								nxt_ctl.sel_glyph    = 1'b0;
								nxt_ctl.rd_buf = display_memory[word.data[6:0]]; // [RL21]
							end else if (word.data[6]) begin
								nxt_ctl.addr_counter = {1'b0, word.data[5:0]}; // [RL11]
								nxt_ctl.sel_glyph    = 1'b1;
								nxt_ctl.rd_buf = glyph_memory[word.data[5:0]]; // [RL21]
							end else if (word.data[5]) begin
								nxt_ctl.mode.bus_width_sel = word.data[B_DL]; // [RL9]
								nxt_ctl.mode.two_line = word.data[B_N]; // [RL10]
								nxt_ctl.mode.font_big = word.data[B_F];
								nxt_ctl.half = 1'b0;
							end else if (word.data[4]) begin
								if (word.data[B_SC]) begin
									// address counter left alone
									nxt_ctl.shift = step_shift(ctl_ff.shift,
										!word.data[B_RL]); // [RL6] [RL7]
								end else begin
									nxt_ctl.addr_counter = step_ac(ctl_ff.addr_counter,
										word.data[B_RL], ctl_ff.sel_glyph,
										ctl_ff.mode.two_line); // [RL6]
									nxt_ctl.rd_buf = display_memory[nxt_ctl.addr_counter];
								end
							end else if (word.data[3]) begin
								nxt_ctl.mode.display_on = word.data[B_DISP]; // [RL5]
								nxt_ctl.mode.cursor_on  = word.data[B_CUR];
								nxt_ctl.mode.blink_on   = word.data[B_BLINK];
							end else if (word.data[2]) begin
								nxt_ctl.mode.entry_inc = word.data[B_ID]; // [RL3]
								nxt_ctl.mode.auto_display_shift_en = word.data[B_SH];
							end else if (word.data[1]) begin
								nxt_ctl.addr_counter = ADDR_HOME; // [RL2]
								nxt_ctl.shift        = 6'h00;
								nxt_ctl.sel_glyph    = 1'b0;
								nxt_ctl.timer        = 18'(LONG_CYCLES);
							end else if (word.data[0]) begin
								nxt_ctl.addr_counter    = ADDR_HOME; // [RL1]
								nxt_ctl.shift           = 6'h00;
								nxt_ctl.sel_glyph       = 1'b0;
								nxt_ctl.mode.entry_inc  = 1'b1;
								nxt_ctl.timer           = 18'(LONG_CYCLES);
								nxt_ctl.sweep           = 7'h00;
								nxt_ctl.exec            = ST_CLEAR;
							end
						end
					endcase
				end
			end
			ST_CLEAR: begin
				// sweep the whole array, far shorter than the busy time
				dm_we         = 1'b1;
				dm_addr       = ctl_ff.sweep;
				dm_wdata      = SPACE_CODE; // [RL1]
				nxt_ctl.sweep = ctl_ff.sweep + 7'h01;
				nxt_ctl.timer = ctl_ff.timer - 18'h00001;
				if (ctl_ff.sweep == SWEEP_LAST) begin
					nxt_ctl.exec = ST_WAIT;
				end
			end
			ST_WAIT: begin
				nxt_ctl.timer = ctl_ff.timer - 18'h00001;
				if (ctl_ff.timer <= 18'h00001) begin
					nxt_ctl.exec = ST_IDLE;
				end
			end
			default: begin
				nxt_ctl.exec = ST_IDLE;
			end
		endcase
		// a queued entry counts as work in progress
		nxt_ctl.busy  = (nxt_ctl.exec != ST_IDLE) || out_valid || push; // [RL23]
		nxt_ctl.pix   = display_memory[pix_addr];
		nxt_ctl.glyph = glyph_memory[glyph_addr];
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (dm_we) begin
			display_memory[dm_addr] <= dm_wdata;
		end
		if (gm_we) begin
			glyph_memory[gm_addr] <= gm_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_ff      <= '0;
			ctl_ff.exec <= ST_IDLE;
			ctl_ff.mode <= MODE_RST;
		end else begin
			ctl_ff <= nxt_ctl;
		end
	end

	assign bus_lines_out = ctl_ff.bus_out;
	assign bus_lines_oe  = ctl_ff.oe;
	assign busy_flag     = ctl_ff.busy;
	assign mode          = ctl_ff.mode;
	assign display_shift = ctl_ff.shift;
	assign pix_char      = ctl_ff.pix;
	assign glyph_row     = ctl_ff.glyph;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence clr_pop;
		pop && word.kind == KIND_CMD && word.data == CMD_CLEAR;
	endsequence
	sequence home_pop;
		pop && word.kind == KIND_CMD && word.data[7:1] == 7'h01;
	endsequence
	sequence wr_pop;
		pop && word.kind == KIND_WR;
	endsequence

	chk_clear_entry: assert property (clr_pop |=> ctl_ff.exec == ST_CLEAR // [RL1]
		&& ctl_ff.addr_counter == ADDR_HOME && ctl_ff.mode.entry_inc)
		else $error("clear did not home and force increment");
	chk_clear_fill: assert property (ctl_ff.exec == ST_CLEAR |-> dm_we // [RL1]
		&& dm_wdata == SPACE_CODE)
		else $error("clear sweep missing space write");
	chk_home_pos: assert property (home_pop |=> ctl_ff.addr_counter == ADDR_HOME // [RL2]
		&& ctl_ff.shift == 6'h00)
		else $error("home left address or shift");
	chk_entry_store: assert property (pop && word.kind == KIND_CMD // [RL3]
		&& word.data[7:2] == 6'h01 |=> ctl_ff.mode.entry_inc == $past(word.data[B_ID]))
		else $error("entry direction not stored");
	chk_wr_noshift: assert property (wr_pop and !ctl_ff.mode.auto_display_shift_en // [RL4]
		|=> $stable(ctl_ff.shift))
		else $error("display shifted without enable");
	chk_dshift_ac: assert property (pop && word.kind == KIND_CMD // [RL7]
		&& word.data[7:3] == 5'h03 |=> $stable(ctl_ff.addr_counter))
		else $error("display shift moved address");
	chk_line_wrap: assert property (wr_pop and !ctl_ff.sel_glyph // [RL8]
		&& ctl_ff.mode.two_line && ctl_ff.mode.entry_inc
		&& ctl_ff.addr_counter == LINE1_END |=> ctl_ff.addr_counter == LINE2_START)
		else $error("cursor did not pass to second line");
	chk_status_rd: assert property (strobe && host_req.rd_wr && !host_req.reg_select // [RL14]
		&& ctl_ff.mode.bus_width_sel |=> bus_lines_oe
		&& bus_lines_out == {$past(ctl_ff.busy), $past(ctl_ff.addr_counter)})
		else $error("status read value wrong");
	chk_wr_busy: assert property (wr_pop |=> (ctl_ff.exec == ST_WAIT)[*8] // [RL15]
		##1 busy_flag)
		else $error("data write busy time cut short");
endmodule

// ===== logic/lcd_pkg.sv
package lcd_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_LONG_NS     = 1520000;
	localparam int T_CMD_NS      = 37000;
	localparam int T_DATA_NS     = 43000;
	localparam int LONG_CYC      = (T_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CMD_CYC       = (T_CMD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DATA_CYC      = (T_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ----------------------------------------
	// codes and addresses
	// ----------------------------------------
	localparam logic [7:0] SPACE_CODE  = 8'h20;
	localparam logic [7:0] CMD_CLEAR   = 8'h01;
	localparam logic [6:0] ADDR_HOME   = 7'h00;
	localparam logic [6:0] LINE1_END   = 7'h27;
	localparam logic [6:0] LINE2_START = 7'h40;
	localparam logic [6:0] LINE2_END   = 7'h67;
	localparam logic [6:0] ONE_END     = 7'h4F;
	localparam logic [6:0] SWEEP_LAST  = 7'h7F;
	localparam logic [5:0] SHIFT_LAST  = 6'h27;
	localparam int DISPLAY_MEMORY_DEPTH = 128;
	localparam int CG_DEPTH    = 64;
	localparam int FIFO_DEPTH  = 16;
	// ----------------------------------------
	// command field positions
	// ----------------------------------------
	localparam int B_ID    = 1;
	localparam int B_SH    = 0;
	localparam int B_DISP  = 2;
	localparam int B_CUR   = 1;
	localparam int B_BLINK = 0;
	localparam int B_SC    = 3;
	localparam int B_RL    = 2;
	localparam int B_DL    = 4;
	localparam int B_N     = 3;
	localparam int B_F     = 2;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {KIND_CMD = 2'h0, KIND_WR = 2'h1, KIND_RD = 2'h2} kind_e;
	typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_CLEAR = 3'h2, ST_WAIT = 3'h4} exec_e;
	typedef struct packed {
		kind_e      kind;
		logic [7:0] data;
	} fifo_word_s;
	typedef struct packed {
		logic       reg_select;
		logic       rd_wr;
		logic [7:0] bus_lines;
	} host_req_s;
	typedef struct packed {
		logic display_on;
		logic cursor_on;
		logic blink_on;
		logic two_line;
		logic font_big;
		logic bus_width_sel;
		logic auto_display_shift_en;
		logic entry_inc;
	} mode_s;
	localparam mode_s MODE_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
endpackage

// ===== tb/lcd_host.sv
`timescale 1ns/1ns
// ----------------------------------------
// host side of the strobed bus
// ----------------------------------------
module lcd_host
	import lcd_pkg::*;
(
	input  wire logic       core_clk,
	output      logic       strobe,
	output      host_req_s  host_req,
	input  wire logic [7:0] bus_lines_out
);
	bit w8 = 1'b1;
	initial begin
		strobe   = 1'b0;
		host_req = '{1'b0, 1'b1, 8'hA5};
	end
	// one strobe; answer taken just after the next edge
	task automatic pulse(input bit rs, input bit rw, input logic [7:0] v, output logic [7:0] rd);
		@(posedge core_clk);
		#1;
		strobe   = 1'b1;
		host_req = '{rs, rw, v};
		@(posedge core_clk);
		#1;
		strobe                = 1'b0;
		// released lines never keep the last value
		host_req.bus_lines    = ~v;
		rd                    = bus_lines_out;
	endtask
	task automatic xfer(input bit rs, input bit rw, input logic [7:0] d, output logic [7:0] rd);
		logic [7:0] hi;
		logic [7:0] lo;
		if (w8) begin
			pulse(rs, rw, d, rd);
		end else begin
			pulse(rs, rw, {d[7:4], ~d[3:0]}, hi);
			pulse(rs, rw, {d[3:0], ~d[7:4]}, lo);
			rd = {hi[7:4], lo[7:4]};
		end
	endtask
	// polls status; nothing new is sent while busy
	task automatic wait_ready(output logic [7:0] st, output bit ok);
		int n;
		ok = 1'b0;
		repeat (3) @(posedge core_clk);
		for (n = 0; n < 5000 && !ok; n++) begin
			xfer(1'b0, 1'b1, 8'h00, st);
			if (st[7] === 1'b0) ok = 1'b1;
		end
		repeat (3) @(posedge core_clk);
	endtask
endmodule

// ===== tb/test_char_lcd_instruction_decoder.sv
`timescale 1ns/1ns
module test_char_lcd_instruction_decoder
	import lcd_pkg::*;
;
	localparam int LONG_T = 300;
	localparam int DATA_T = 20;
	logic       core_clk;
	logic       rst_n;
	logic       strobe;
	host_req_s  host_req;
	logic [7:0] bus_lines_out;
	logic       bus_lines_oe;
	logic       busy_flag;
	mode_s      mode;
	logic [5:0] display_shift;
	logic [6:0] pix_addr;
	logic [7:0] pix_char;
	logic [5:0] glyph_addr;
	logic [7:0] glyph_row;
	int         miscompares = 0;
	int         n_tests = 0;
	int         busy_len = 0;
	int         run = 0;
	int         ac = 0;
	int         sft = 0;
	bit         gsel = 1'b0;
	bit         rdv = 1'b0;
	mode_s      em = 8'h05;
	logic [7:0] dd [128];
	logic [7:0] cg [64];
	logic [7:0] r [6];
	int         i;
	lcd_decoder #(.LONG_CYCLES(LONG_T), .DATA_CYCLES(DATA_T)) dut_u (
		.core_clk(core_clk), .rst_n(rst_n), .strobe(strobe), .host_req(host_req),
		.bus_lines_out(bus_lines_out), .bus_lines_oe(bus_lines_oe), .busy_flag(busy_flag),
		.mode(mode), .display_shift(display_shift), .pix_addr(pix_addr),
		.pix_char(pix_char), .glyph_addr(glyph_addr), .glyph_row(glyph_row));
	lcd_host host_u (
		.core_clk(core_clk), .strobe(strobe), .host_req(host_req),
		.bus_lines_out(bus_lines_out));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// length of the last busy stretch
	always @(posedge core_clk) begin
		if (busy_flag === 1'b1) run <= run + 1;
		else begin
			if (run != 0) busy_len <= run;
			run <= 0;
		end
	end
	// ----------------------------------------
	// checking
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	// ----------------------------------------
	// reference model
	// ----------------------------------------
	function automatic int step(input int a, input bit up);
		int n;
		n = up ? a + 1 : a - 1;
		if (gsel) return n & 63;
		if (em.two_line) begin
			if (n == 7'h28) n = up ? 7'h40 : n;
			if (n == 7'h3F) n = 7'h27;
			if (n == 7'h68) n = 7'h00;
			if (n < 0) n = 7'h67;
		end else begin
			if (n == 7'h50) n = 7'h00;
			if (n < 0) n = 7'h4F;
		end
		return n;
	endfunction
	task automatic mdl(input bit rs, input bit rw, input logic [7:0] d,
			output logic [7:0] er, output int cyc);
		er  = 8'h00;
		cyc = CMD_CYC;
		if (rs) begin
			cyc = DATA_T;
			if (rw) er = gsel ? cg[ac] : dd[ac];
			else begin
				if (gsel) cg[ac] = d;
				else dd[ac] = d;
				if (!gsel && em.auto_display_shift_en) sft = (sft + (em.entry_inc ? 1 : 39)) % 40;
				rdv = 1'b0;
			end
			ac = step(ac, em.entry_inc);
		end else begin
			rdv = 1'b0;
			casez (d)
				8'b1???????: begin ac = d[6:0]; gsel = 1'b0; rdv = 1'b1; end
				8'b01??????: begin ac = d[5:0]; gsel = 1'b1; rdv = 1'b1; end
				8'b001?????: begin em.bus_width_sel = d[4]; em.two_line = d[3]; em.font_big = d[2]; end
				8'b0001????: begin
					if (d[3]) sft = (sft + (d[2] ? 39 : 1)) % 40;
					else begin ac = step(ac, d[2]); rdv = 1'b1; end
				end
				8'b00001???: begin em.display_on = d[2]; em.cursor_on = d[1]; em.blink_on = d[0]; end
				8'b000001??: begin em.entry_inc = d[1]; em.auto_display_shift_en = d[0]; end
				8'b0000001?: begin ac = 0; sft = 0; gsel = 1'b0; cyc = LONG_T; end
				8'b00000001: begin
					for (int k = 0; k < 128; k++) dd[k] = 8'h20;
					ac = 0; sft = 0; gsel = 1'b0; em.entry_inc = 1'b1; cyc = LONG_T;
				end
				default: ;
			endcase
		end
	endtask
	// ----------------------------------------
	// one bus operation, then status, busy time, output enable, mode, shift and valid read data compared
	// ----------------------------------------
	task automatic op(input bit rs, input bit rw, input logic [7:0] d);
		logic [7:0] er;
		logic [7:0] rd;
		logic [7:0] st;
		int         cyc;
		bit         v;
		bit         ok;
		v = rdv;
		mdl(rs, rw, d, er, cyc);
		busy_len = 0;
		host_u.xfer(rs, rw, d, rd);
		// nibble phase restarts as soon as the width changes
		if (!rs && d[7:5] == 3'b001) host_u.w8 = d[4];
		host_u.wait_ready(st, ok);
		if (!ok) begin
			miscompares++;
			report_and_stop();
		end
		if (rs && rw && v) chk(rd, er);
		n_tests++;
		if (busy_len < cyc || busy_len > cyc + 4) begin
			miscompares++;
			$display("Error at %0t: busy %h expected %h", $time, busy_len, cyc);
		end
		chk(st, {1'b0, 7'(ac)});
		chk({7'h00, bus_lines_oe}, 8'h01);
		chk(mode, em);
		chk({2'b00, display_shift}, 8'(sft));
	endtask
	task automatic pix_all;
		for (int k = 0; k < 128; k++) begin
			@(posedge core_clk);
			#1 pix_addr = 7'(k);
			repeat (2) @(posedge core_clk);
			#1 chk(pix_char, dd[k]);
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst_n      = 1'b0;
		pix_addr   = 7'h00;
		glyph_addr = 6'h00;
		repeat (8) @(posedge core_clk);
		#1 rst_n = 1'b1;
		void'($urandom(26));
		for (i = 0; i < 6; i++) r[i] = 8'($urandom);
		chk(mode, em);
		chk({7'h00, busy_flag}, 8'h00);
		chk({bus_lines_oe, 1'b0, display_shift}, 8'h00);
		done("reset");
		op(1'b0, 1'b0, 8'h3F);
		op(1'b0, 1'b0, 8'h0F);
		op(1'b0, 1'b0, 8'h01);
		pix_all();
		done("clear");
		op(1'b0, 1'b0, 8'hA7);
		op(1'b1, 1'b0, r[0]);
		op(1'b1, 1'b0, r[1]);
		op(1'b0, 1'b0, 8'hA7);
		op(1'b1, 1'b1, 8'h00);
		op(1'b1, 1'b1, 8'h00);
		done("two_line");
		op(1'b0, 1'b0, 8'h07);
		op(1'b1, 1'b0, r[2]);
		op(1'b0, 1'b0, 8'h05);
		op(1'b1, 1'b0, r[3]);
		done("entry");
		op(1'b0, 1'b0, 8'h10);
		op(1'b0, 1'b0, 8'h14);
		op(1'b0, 1'b0, 8'h1B);
		op(1'b0, 1'b0, 8'h1C);
		done("shift");
		op(1'b0, 1'b0, 8'h07);
		op(1'b0, 1'b0, 8'h7F);
		op(1'b1, 1'b0, r[4]);
		@(posedge core_clk);
		#1 glyph_addr = 6'h3F;
		repeat (2) @(posedge core_clk);
		#1 chk(glyph_row, cg[63]);
		op(1'b0, 1'b0, 8'h7F);
		op(1'b1, 1'b1, 8'h00);
		done("glyph");
		op(1'b0, 1'b0, 8'h18);
		op(1'b0, 1'b0, 8'h02);
		pix_all();
		done("home");
		op(1'b0, 1'b0, 8'h28);
		op(1'b0, 1'b0, 8'h90);
		op(1'b1, 1'b0, r[5]);
		op(1'b0, 1'b0, 8'h90);
		op(1'b1, 1'b1, 8'h00);
		done("nibble");
		op(1'b0, 1'b0, 8'h20);
		op(1'b0, 1'b0, 8'hCF);
		op(1'b1, 1'b0, r[0]);
		op(1'b0, 1'b0, 8'h04);
		op(1'b1, 1'b0, r[1]);
		pix_all();
		done("one_line");
		report_and_stop();
	end
endmodule
